/* rtl/delay_counter.v */
// reloadable down counter with a one-cycle expiry pulse
`timescale 1ns/1ps
module delay_counter #(
  parameter WIDTH = 24
) (
  // system
  input  wire             clk,
  input  wire             rst_n,
  // control
  input  wire             load,
  input  wire             enable,
  input  wire [WIDTH-1:0] count_val,
  // status
  output reg              expired
);

  reg [WIDTH-1:0] count_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= {WIDTH{1'b0}};
      expired   <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (load) begin
        count_reg <= count_val;
      end else if (enable && count_reg != {WIDTH{1'b0}}) begin
        count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
        // pulse as the count lands on zero
        expired   <= (count_reg == {{(WIDTH-1){1'b0}}, 1'b1});
      end
    end
  end

endmodule

/* rtl/pin_sync.v */
// two-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 3
) (
  // system
  input  wire             clk,
  input  wire             rst_n,
  // pins
  input  wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;

endmodule

/* rtl/sleep_wakeup_regs.vh */
// register offsets, fields, reset values and timing for the sleep wake-up logic
`ifndef SLEEP_WAKEUP_REGS_VH
`define SLEEP_WAKEUP_REGS_VH

// byte offsets
`define CTRL_OFF        8'h00
`define INT_EN_OFF      8'h04
`define INT_PRIO_OFF    8'h08
`define RESET_CTRL_OFF  8'h0C
`define IRQ_STATUS_OFF  8'h10
`define IRQ_MASK_OFF    8'h14
`define STATE_OFF       8'h18

// control fields
`define CTRL_WDT_EN     0
`define CTRL_CFM_EN     1
`define CTRL_XTAL_ON    2
`define CTRL_WDT_KICK   3
`define CTRL_LEVEL_LSB  4
`define CTRL_RESET      32'h0000_0000

// reset control fields
`define RC_SLEEP        0
`define RC_WATCHDOG_TIMEOUT_FLAG         1
`define RC_CLK_FAIL     2

// interrupt status fields
`define IS_WAKE         0
`define IS_CLK_FAIL     1
`define IS_WATCHDOG_TIMEOUT_FLAG         2

// timing, in ns at a 4 ns clock
`define CLK_PERIOD_NS   4
`define POWER_ON_NS     10000
`define PLL_LOCK_NS     20000
`define POWER_UP_NS     64000
`define WDT_PERIOD_NS   2000000

`endif

/* rtl/sleep_wakeup_status_logic.v */
// sleep wake-up, start-up clock check and status flags behind an axi4-lite slave
`timescale 1ns/1ps
`include "sleep_wakeup_regs.vh"
module sleep_wakeup_status_logic #(
  parameter POR_CYCLES  = (`POWER_ON_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter LOCK_CYCLES = (`PLL_LOCK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter PWRT_CYCLES = (`POWER_UP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter WDT_CYCLES  = `WDT_PERIOD_NS / `CLK_PERIOD_NS
) (
  // system
  input  wire        clk,
  input  wire        rst_n,
  // axi write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi read address
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // interrupt sources and core handshake, same clock
  input  wire [7:0]  irq_req,
  input  wire        sleep_req,
  // asynchronous pins
  input  wire        osc_running,
  input  wire        mclr_n,
  input  wire        brown_out,
  // core control
  output reg         cpu_run,
  output reg         cpu_reset,
  output reg         isr_take,
  output reg  [2:0]  isr_vector,
  output reg         clk_fail_trap,
  // oscillator selection
  output reg         frc_enable,
  output reg         xtal_enable,
  // interrupt
  output reg         irq
);

  ////////////////////////////////////////////////////////////////////////////
  localparam [1:0] ST_START = 2'b00;
  localparam [1:0] ST_RUN   = 2'b01;
  localparam [1:0] ST_SLEEP = 2'b10;
  localparam [1:0] ST_HOLD  = 2'b11;
  localparam [31:0] START_SUM = POR_CYCLES + LOCK_CYCLES + PWRT_CYCLES;
  localparam [31:0] WDT_SUM   = WDT_CYCLES;

  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a == `CTRL_OFF) || (a == `INT_EN_OFF) || (a == `INT_PRIO_OFF) ||
                (a == `RESET_CTRL_OFF) || (a == `IRQ_STATUS_OFF) ||
                (a == `IRQ_MASK_OFF) || (a == `STATE_OFF);
    end
  endfunction

  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer      k;
    begin
      wmerge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          wmerge[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [31:0] ctrl_reg;
  reg  [7:0]  int_en_reg;
  reg  [23:0] int_prio_reg;
  reg  [2:0]  rc_reg;
  reg  [2:0]  istat_reg;
  reg  [2:0]  imask_reg;
  reg         start_load_reg;
  reg         isr_pend_reg;
  reg  [2:0]  vec_pend_reg;
  wire [2:0]  pin_q;
  wire        osc_ok;
  wire        ext_rst;
  wire        start_done;
  wire        wdt_expired;
  wire [7:0]  qual;
  wire        wr_fire;
  wire        rd_fire;
  wire        wr_ctrl;
  wire        wdt_en;
  wire        cfm_en;
  wire        clk_ok;
  wire        irq_wake;
  wire        wdt_wake;
  wire        fail_over;
  reg  [2:0]  best_vec;
  reg  [2:0]  best_prio;
  reg         any_qual;
  reg  [31:0] rd_mux;
  integer     j;
  wire [31:0] en_merge   = wmerge({24'h0, int_en_reg}, s_axi_wdata, s_axi_wstrb);
  wire [31:0] prio_merge = wmerge({8'h00, int_prio_reg}, s_axi_wdata, s_axi_wstrb);

  ////////////////////////////////////////////////////////////////////////////
  // pins cross in through two flops; mclr inverted so reset state reads idle
  pin_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({osc_running, ~mclr_n, brown_out}),
    .q     (pin_q)
  );

  assign osc_ok  = pin_q[2];
  assign ext_rst = pin_q[1] | pin_q[0];
  assign wdt_en  = ctrl_reg[`CTRL_WDT_EN];
  assign cfm_en  = ctrl_reg[`CTRL_CFM_EN];
  assign clk_ok  = osc_ok | frc_enable;

  // start-up delays run back to back as one count
  delay_counter #(
    .WIDTH (24)
  ) u_start_cnt (
    .clk       (clk),
    .rst_n     (rst_n),
    .load      (start_load_reg | ext_rst),
    .enable    (state_reg == ST_START),
    .count_val (START_SUM[23:0]),
    .expired   (start_done)
  );

  // watchdog: reloaded on kick, on expiry and while disabled
  delay_counter #(
    .WIDTH (24)
  ) u_wdt_cnt (
    .clk       (clk),
    .rst_n     (rst_n),
    .load      (!wdt_en || wdt_expired || (wr_ctrl && s_axi_wdata[`CTRL_WDT_KICK])),
    .enable    (wdt_en),
    .count_val (WDT_SUM[23:0]),
    .expired   (wdt_expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // per-source qualification: enabled and above the current level
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_qual
      assign qual[g] = irq_req[g] & int_en_reg[g] &
                       (int_prio_reg[g*3 +: 3] > ctrl_reg[`CTRL_LEVEL_LSB +: 3]);
    end
  endgenerate

  // highest priority wins; lowest index on a tie
  always @* begin
    best_vec  = 3'h0;
    best_prio = 3'h0;
    any_qual  = 1'b0;
    for (j = 7; j >= 0; j = j - 1) begin
      if (qual[j] && (!any_qual || int_prio_reg[j*3 +: 3] >= best_prio)) begin
        best_vec  = j[2:0];
        best_prio = int_prio_reg[j*3 +: 3];
        any_qual  = 1'b1;
      end
    end
  end

  assign irq_wake  = (state_reg == ST_SLEEP) && any_qual;
  assign wdt_wake  = (state_reg == ST_SLEEP) && wdt_en && wdt_expired;
  assign fail_over = (state_reg == ST_START) && start_done && !osc_ok && cfm_en;

  ////////////////////////////////////////////////////////////////////////////
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_START: begin
        if (start_done) begin
          if (osc_ok || cfm_en) begin
            state_next = ST_RUN;
          end else begin
            state_next = ST_HOLD;
          end
        end
      end
      ST_RUN: begin
        if (sleep_req) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        // any one source ends sleep; no clock means wait in hold
        if (irq_wake || wdt_wake) begin
          state_next = clk_ok ? ST_RUN : ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (clk_ok) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_START;
      end
    endcase
    // a reset restarts from any state, sleep included
    if (ext_rst) begin
      state_next = ST_START;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core side
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg      <= ST_START;
      start_load_reg <= 1'b1;
      cpu_run        <= 1'b0;
      cpu_reset      <= 1'b1;
      isr_take       <= 1'b0;
      isr_vector     <= 3'h0;
      isr_pend_reg   <= 1'b0;
      vec_pend_reg   <= 3'h0;
      clk_fail_trap  <= 1'b0;
      frc_enable     <= 1'b0;
      xtal_enable    <= 1'b1;
    end else begin
      state_reg      <= state_next;
      start_load_reg <= 1'b0;
      cpu_run        <= (state_next == ST_RUN);
      cpu_reset      <= ext_rst;
      clk_fail_trap  <= fail_over;
      isr_take       <= 1'b0;
      if (irq_wake) begin
        isr_pend_reg <= 1'b1;
        vec_pend_reg <= best_vec;
      end else if (state_reg == ST_RUN && isr_pend_reg) begin
        // branch to the handler once the core runs again
        isr_take     <= 1'b1;
        isr_vector   <= vec_pend_reg;
        isr_pend_reg <= 1'b0;
      end
      if (ext_rst) begin
        isr_pend_reg <= 1'b0;
      end
      if (fail_over) begin
        frc_enable  <= 1'b1;
        xtal_enable <= 1'b0;
      end else if (wr_ctrl && s_axi_wstrb[0] && s_axi_wdata[`CTRL_XTAL_ON]) begin
        xtal_enable <= 1'b1;
      end else if (frc_enable && xtal_enable && osc_ok) begin
        // leave the rc only once the crystal really runs
        frc_enable <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: address and data taken together, one of each in flight
  assign wr_fire = s_axi_awready;
  assign rd_fire = s_axi_arready;
  assign wr_ctrl = wr_fire && (s_axi_awaddr == `CTRL_OFF);

  always @* begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      `CTRL_OFF:       rd_mux = {25'h0, ctrl_reg[6:4], 2'b00, ctrl_reg[1:0]};
      `INT_EN_OFF:     rd_mux = {24'h0, int_en_reg};
      `INT_PRIO_OFF:   rd_mux = {8'h00, int_prio_reg};
      `RESET_CTRL_OFF: rd_mux = {29'h0, rc_reg};
      `IRQ_STATUS_OFF: rd_mux = {29'h0, istat_reg};
      `IRQ_MASK_OFF:   rd_mux = {29'h0, imask_reg};
      `STATE_OFF:      rd_mux = {26'h0, osc_ok, xtal_enable, frc_enable, cpu_run, state_reg};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'b00;
      s_axi_rdata   <= 32'h0000_0000;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_ok(s_axi_awaddr) ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= addr_ok(s_axi_araddr) ? 2'b00 : 2'b10;
        s_axi_rdata  <= rd_mux;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; for sticky flags a set in the clearing cycle wins
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg     <= `CTRL_RESET;
      int_en_reg   <= 8'h00;
      int_prio_reg <= 24'h00_0000;
      rc_reg       <= 3'h0;
      istat_reg    <= 3'h0;
      imask_reg    <= 3'h0;
      irq          <= 1'b0;
    end else begin
      if (wr_fire) begin
        case (s_axi_awaddr)
          `CTRL_OFF:     ctrl_reg     <= wmerge(ctrl_reg, s_axi_wdata, s_axi_wstrb) &
                                         32'h0000_0073;
          `INT_EN_OFF:   int_en_reg   <= en_merge[7:0];
          `INT_PRIO_OFF: int_prio_reg <= prio_merge[23:0];
          `IRQ_MASK_OFF: imask_reg    <= s_axi_wstrb[0] ? s_axi_wdata[2:0] : imask_reg;
          default:       ctrl_reg     <= ctrl_reg;
        endcase
      end
      if (wr_fire && s_axi_awaddr == `RESET_CTRL_OFF && s_axi_wstrb[0]) begin
        rc_reg <= (rc_reg & ~s_axi_wdata[2:0]) |
                  {fail_over, wdt_expired && wdt_en, irq_wake | wdt_wake | ext_rst};
      end else begin
        rc_reg[`RC_SLEEP]    <= rc_reg[`RC_SLEEP] | irq_wake | wdt_wake |
                                ext_rst;
        rc_reg[`RC_WATCHDOG_TIMEOUT_FLAG]     <= rc_reg[`RC_WATCHDOG_TIMEOUT_FLAG] | (wdt_expired && wdt_en);
        rc_reg[`RC_CLK_FAIL] <= rc_reg[`RC_CLK_FAIL] | fail_over;
      end
      if (wr_fire && s_axi_awaddr == `IRQ_STATUS_OFF && s_axi_wstrb[0]) begin
        istat_reg <= (istat_reg & ~s_axi_wdata[2:0]) |
                     {wdt_expired && wdt_en, fail_over, irq_wake | wdt_wake};
      end else begin
        istat_reg <= istat_reg | {wdt_expired && wdt_en, fail_over, irq_wake | wdt_wake};
      end
      irq <= |(istat_reg & imask_reg);
    end
  end

endmodule

/* tb/sleep_wakeup_status_logic_sva.sv */
// checker: wake-up, reset, clock failure and bus timing properties
`timescale 1ns/1ps
module sleep_wakeup_sva (
  // system
  input logic       clk,
  input logic       rst_n,
  // bus handshakes
  input logic       s_axi_awvalid,
  input logic       s_axi_wvalid,
  input logic       s_axi_awready,
  input logic       s_axi_wready,
  input logic       s_axi_bvalid,
  input logic       s_axi_arvalid,
  input logic       s_axi_arready,
  input logic       s_axi_rvalid,
  // wake sources and pins
  input logic [7:0] irq_req,
  input logic       osc_running,
  input logic       mclr_n,
  input logic       brown_out,
  // core and oscillator control
  input logic       cpu_run,
  input logic       cpu_reset,
  input logic       isr_take,
  input logic [2:0] isr_vector,
  input logic       clk_fail_trap,
  input logic       frc_enable,
  input logic       xtal_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  property p_isr_src;
    isr_take |-> cpu_run && irq_req[isr_vector];
  endproperty
  a_isr_src: assert property (p_isr_src) else $error("handler taken without request");
  property p_isr_wake;
    isr_take |-> $past(cpu_run) && !$past(cpu_run, 2);
  endproperty
  a_isr_wake: assert property (p_isr_wake) else $error("handler not right after wake");
  property p_fail;
    clk_fail_trap |-> ##[0:1] (frc_enable && !xtal_enable);
  endproperty
  a_fail: assert property (p_fail) else $error("trap without rc switch-over");
  // a valid clock is either the synced crystal or the rc fallback
  property p_clk_ok;
    $rose(cpu_run) |-> frc_enable || $past(osc_running, 2);
  endproperty
  a_clk_ok: assert property (p_clk_ok) else $error("run started without clock");
  property p_pin_rst;
    (!mclr_n || brown_out) [*4] |=> cpu_reset && !cpu_run;
  endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("pin reset not taken");
  property p_rst_hold;
    cpu_reset |=> !cpu_run;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("running during reset");
  property p_aw;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready |=>
      s_axi_awready && s_axi_wready;
  endproperty
  a_aw: assert property (p_aw) else $error("write not taken");
  property p_b;
    s_axi_awready |=> s_axi_bvalid && !s_axi_awready;
  endproperty
  a_b: assert property (p_b) else $error("write response late");
  property p_r;
    s_axi_arvalid && !s_axi_rvalid && !s_axi_arready |=> s_axi_arready ##1 s_axi_rvalid;
  endproperty
  a_r: assert property (p_r) else $error("read not answered");
endmodule

bind sleep_wakeup_status_logic sleep_wakeup_sva sleep_wakeup_sva_i (
  .clk, .rst_n, .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .irq_req, .osc_running, .mclr_n, .brown_out,
  .cpu_run, .cpu_reset, .isr_take, .isr_vector, .clk_fail_trap, .frc_enable, .xtal_enable);

/* tb/tb_sleep_wakeup_status_logic.sv */
// testbench: random and corner wake-up, reset and clock-failure scenarios
`timescale 1ns/1ps
`include "sleep_wakeup_regs.vh"
module tb_sleep_wakeup_status_logic;
  logic        clk, rst_n, sleep_req, osc_running, mclr_n, brown_out, m;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, irq_req, en, req;
  logic [31:0] s_axi_wdata, d;
  logic [23:0] pr;
  logic [2:0]  lvl, s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  resp;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         cpu_run, cpu_reset, isr_take, clk_fail_trap, frc_enable, xtal_enable, irq;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [2:0]   isr_vector;
  integer      failures, n_compared, seed, n, k, s, t;
  ////////////////////////////////////////////////////////////////////////////////
  // short start-up and watchdog counts keep the run brief
  sleep_wakeup_status_logic #(.POR_CYCLES(4), .LOCK_CYCLES(4), .PWRT_CYCLES(4), .WDT_CYCLES(60))
  sleep_wakeup_status_logic_i (
    .clk, .rst_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_req,
    .sleep_req, .osc_running, .mclr_n, .brown_out, .cpu_run, .cpu_reset, .isr_take,
    .isr_vector, .clk_fail_trap, .frc_enable, .xtal_enable, .irq);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task close_out;
    if (failures == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // every wait is bounded; running out counts as a failure
  task tick;
    @(posedge clk);
    n = n + 1;
    if (n > 400) begin
      failures = failures + 1;
      close_out;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awprot <= 3'($random(seed));
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do tick; while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do tick; while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask
  task rd(input [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arprot <= 3'($random(seed));
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do tick; while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do tick; while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  task nap;
    @(posedge clk) sleep_req <= 1'b1;
    @(posedge clk) sleep_req <= 1'b0;
  endtask
  task wait_run;
    n = 0;
    while (cpu_run !== 1'b1) tick;
  endtask
  // highest priority above the level wins, lowest index on a tie; 8 means none
  function [3:0] winner(input [7:0] rq, input [7:0] ie, input [23:0] p, input [2:0] l);
    integer i;
    reg [2:0] bp;
    winner = 4'h8;
    bp = l;
    for (i = 0; i < 8; i = i + 1)
      if (rq[i] && ie[i] && p[3*i +: 3] > bp) begin
        winner = i[3:0];
        bp = p[3*i +: 3];
      end
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h1206;
    failures = 0;
    n_compared = 0;
    {rst_n, sleep_req, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 6'h0;
    {s_axi_rready, brown_out, irq_req, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 58'h0;
    osc_running = 1'b1;
    mclr_n = 1'b1;
    s_axi_wstrb = 4'hF;
    s_axi_awprot = 3'h0;
    s_axi_arprot = 3'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    wait_run;
    rd(`RESET_CTRL_OFF);
    chk(d[`RC_SLEEP], 1'b0);
    rd(`STATE_OFF);
    chk(d, 32'h0000_0035);
    rd(8'h40);
    chk(d, 32'h0);
    chk(resp, 2'h2);
    wr(8'h40, 32'hFFFF_FFFF);
    chk(resp, 2'h2);
    // byte strobes: only the strobed byte of the priority word changes
    wr(`INT_PRIO_OFF, 32'h00FF_FFFF);
    s_axi_wstrb <= 4'h2;
    wr(`INT_PRIO_OFF, 32'h0);
    s_axi_wstrb <= 4'hF;
    rd(`INT_PRIO_OFF);
    chk(d, 32'h00FF_00FF);
    for (k = 0; k < 4; k = k + 1) begin
      wr(`RESET_CTRL_OFF, 32'h7);
      wr(`IRQ_STATUS_OFF, 32'h7);
      lvl = $random(seed);
      if (lvl == 3'h7) lvl = 3'h6;
      s = $random(seed) & 7;
      t = (s + 1 + k) % 8;
      en = $random(seed) | (8'h1 << s) | (8'h1 << t);
      pr = 24'h0;
      pr[3*s +: 3] = lvl + 3'h1;
      // first pass is a priority tie between the two sources
      pr[3*t +: 3] = (k == 0) ? lvl + 3'h1 : 3'h7;
      m = $random(seed);
      wr(`CTRL_OFF, {25'h0, lvl, 4'h0});
      wr(`INT_EN_OFF, en);
      wr(`INT_PRIO_OFF, pr);
      wr(`IRQ_MASK_OFF, m);
      nap;
      req = ~((8'h1 << s) | (8'h1 << t));
      irq_req <= req;
      repeat (12) @(posedge clk);
      chk(cpu_run, winner(req, en, pr, lvl) != 4'h8);
      irq_req <= 8'hFF;
      n = 0;
      while (isr_take !== 1'b1) tick;
      chk(isr_vector, winner(8'hFF, en, pr, lvl));
      irq_req <= 8'h0;
      repeat (2) @(posedge clk);
      chk(irq, m);
      rd(`RESET_CTRL_OFF);
      chk(d[`RC_SLEEP], 1'b1);
    end
    wr(`RESET_CTRL_OFF, 32'h7);
    wr(`CTRL_OFF, 32'h9);
    nap;
    repeat (5) @(posedge clk);
    chk(cpu_run, 1'b0);
    wait_run;
    rd(`RESET_CTRL_OFF);
    chk(d[1:0], 2'h3);
    rd(`IRQ_STATUS_OFF);
    chk(d[`IS_WATCHDOG_TIMEOUT_FLAG], 1'b1);
    wr(`CTRL_OFF, 32'h0);
    for (k = 0; k < 3; k = k + 1) begin
      wr(`RESET_CTRL_OFF, 32'h7);
      nap;
      // last pass starts with a dead crystal and the monitor off
      if (k == 2) osc_running <= 1'b0;
      if (k == 1) brown_out <= 1'b1;
      else mclr_n <= 1'b0;
      repeat (6) @(posedge clk);
      chk({cpu_reset, cpu_run}, 2'h2);
      mclr_n <= 1'b1;
      brown_out <= 1'b0;
      if (k == 2) begin
        repeat (40) @(posedge clk);
        chk(cpu_run, 1'b0);
        osc_running <= 1'b1;
      end
      wait_run;
      rd(`RESET_CTRL_OFF);
      chk(d[`RC_SLEEP], 1'b1);
    end
    wr(`CTRL_OFF, 32'h2);
    osc_running <= 1'b0;
    brown_out <= 1'b1;
    repeat (6) @(posedge clk);
    brown_out <= 1'b0;
    n = 0;
    while (clk_fail_trap !== 1'b1) tick;
    repeat (2) @(posedge clk);
    chk({frc_enable, xtal_enable}, 2'h2);
    wait_run;
    rd(`RESET_CTRL_OFF);
    chk(d[`RC_CLK_FAIL], 1'b1);
    rd(`IRQ_STATUS_OFF);
    chk(d[`IS_CLK_FAIL], 1'b1);
    osc_running <= 1'b1;
    wr(`CTRL_OFF, 32'h6);
    repeat (4) @(posedge clk);
    chk({frc_enable, xtal_enable}, 2'h1);
    close_out;
  end
endmodule
